// ===== icd_pkg.sv
// package: constants and carrier types of the instruction cache diagnostic control block
`default_nettype none
package icd_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_SEL = 32'h0000_0000;
  localparam logic [31:0] OFF_WORD = 32'h0000_0004;
  localparam logic [31:0] OFF_CHECK = 32'h0000_0008;
  localparam logic [31:0] OFF_GO = 32'h0000_000C;
  localparam logic [31:0] OFF_REGION = 32'h0000_0010;
  localparam logic [31:0] OFF_DBG = 32'h0000_0014;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SEL_ARRAY_BIT = 24;
  localparam int unsigned SEL_WAY_LSB = 20;
  localparam int unsigned SEL_IDX_LSB = 2;
  localparam int unsigned TAG_LSB = 12;
  localparam int unsigned LRU_LSB = 4;
  localparam int unsigned VALID_BIT = 0;
  localparam int unsigned GO_BIT = 0;
  localparam int unsigned FENCE_BIT = 0;
  // ----------------------------------------------------------------
  // geometry and widths
  // ----------------------------------------------------------------
  localparam int unsigned WAYS = 4;
  localparam int unsigned SETS = 2;
  localparam int unsigned CHUNKS = 16;
  localparam int unsigned REGIONS = 16;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned CHECK_W = 10;
  localparam int unsigned TAG_W = 20;
  localparam int unsigned TCHK_W = 7;
  localparam int unsigned LRU_W = 3;
  localparam int unsigned DATA_N = WAYS * SETS * CHUNKS;
  localparam int unsigned TAG_N = WAYS * SETS;
  localparam int unsigned DATA_E_W = CHECK_W + 32;
  localparam int unsigned TAG_E_W = TCHK_W + TAG_W;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [CHECK_W-1:0] RST_CHECK = 10'h000;
  localparam logic [REGIONS-1:0] RST_REGION = 16'h0000;
  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } icd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } icd_apb_rsp_t;

  typedef struct packed {
    logic sel_array;
    logic [1:0] sel_way;
    logic [IDX_W-1:0] sel_idx;
    logic [31:0] word;
    logic [CHECK_W-1:0] check;
    logic [REGIONS-1:0] cacheable;
    logic flush;
    logic [DATA_N-1:0][DATA_E_W-1:0] data;
    logic [TAG_N-1:0][TAG_E_W-1:0] tag;
    logic [TAG_N-1:0] valid;
    logic [SETS-1:0][LRU_W-1:0] lru;
  } icd_state_t;
endpackage
`default_nettype wire

// ===== icd_tb.sv
// testbench: register-bus checks of the instruction cache diagnostic control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // stimulus signals and counters
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  icd_pkg::icd_apb_req_t req = '0;
  icd_pkg::icd_apb_rsp_t rsp;
  logic debug_mode = 1'b1;
  logic [31:0] fetch_addr = 32'h0000_0000;
  logic [15:0] region_cacheable;
  logic cache_enabled;
  logic fetch_cacheable;
  logic icache_flush;
  logic [31:0] rdat;
  logic rerr;
  int num_errors = 0;
  int compares = 0;

  icd_top icd_top_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .debug_mode(debug_mode), .fetch_addr(fetch_addr),
    .region_cacheable(region_cacheable), .cache_enabled(cache_enabled),
    .fetch_cacheable(fetch_cacheable), .icache_flush(icache_flush));

  // 200 MHz clock
  initial forever #2.5 pclk = ~pclk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one transfer; the answer is taken at the rising edge where pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 16)
    begin
      num_errors++;
      $display("Error pready expected 1 seen timeout");
      tally_and_finish();
    end
    else
    begin
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write slverr", {31'h0, rerr}, 32'h0);
  endtask

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rdat, exp);
    chk("read slverr", {31'h0, rerr}, 32'h0);
  endtask

  function automatic logic [31:0] sel(input logic ar, input logic [1:0] w, input logic [4:0] i);
    return (32'(ar) << 24) | (32'(w) << 20) | (32'(i) << 2);
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_select();
    rd("selection reset", icd_pkg::OFF_SEL, 32'h0000_0000);
    chk("cache_enabled reset", {31'h0, cache_enabled}, 32'h0);
    wr(icd_pkg::OFF_SEL, 32'hFFFF_FFFF);
    rd("selection", icd_pkg::OFF_SEL, 32'h0130_007C);
    wr(icd_pkg::OFF_CHECK, 32'hFFFF_FFFF);
    rd("check bits", icd_pkg::OFF_CHECK, 32'h0000_03FF);
    rd("debug ctl", icd_pkg::OFF_DBG, 32'h0000_0000);
  endtask

  // refused accesses must leave state alone
  task automatic t_refuse();
    apb(1'b0, 32'h0000_0018, 32'h0);
    chk("unmapped slverr", {31'h0, rerr}, 32'h1);
    @(posedge pclk);
    debug_mode <= 1'b0;
    apb(1'b0, icd_pkg::OFF_SEL, 32'h0);
    chk("machine slverr", {31'h0, rerr}, 32'h1);
    chk("machine rdata", rdat, 32'h0);
    apb(1'b1, icd_pkg::OFF_SEL, 32'h0);
    chk("machine write slverr", {31'h0, rerr}, 32'h1);
    wr(icd_pkg::OFF_REGION, 32'h0000_0004);
    @(posedge pclk);
    debug_mode <= 1'b1;
    rd("selection kept", icd_pkg::OFF_SEL, 32'h0130_007C);
  endtask

  // whole lines in every way, wrong check bits stored as given
  task automatic t_line();
    for (int p = 0; p < 2; p++)
      for (int w = 0; w < 4; w++)
        for (int c = 0; c < 16; c++)
        begin
          wr(icd_pkg::OFF_SEL, sel(1'b0, 2'(w), 5'(16 + c)));
          if (p == 0)
          begin
            wr(icd_pkg::OFF_WORD, 32'hC0DE_0000 | 32'(w << 8) | 32'(c));
            wr(icd_pkg::OFF_CHECK, 32'(w * 64 + c * 4 + 3));
            wr(icd_pkg::OFF_GO, 32'h0000_0001);
          end
          else
          begin
            rd("go read", icd_pkg::OFF_GO, 32'h0000_0000);
            rd("chunk", icd_pkg::OFF_WORD, 32'hC0DE_0000 | 32'(w << 8) | 32'(c));
            rd("chunk check", icd_pkg::OFF_CHECK, 32'(w * 64 + c * 4 + 3));
          end
        end
  endtask

  // tag, valid and lru round trip, then fence wipes valid only
  task automatic t_tag();
    wr(icd_pkg::OFF_SEL, sel(1'b1, 2'd1, 5'd16));
    wr(icd_pkg::OFF_WORD, 32'hABCD_E5D1);
    wr(icd_pkg::OFF_CHECK, 32'h0000_03F5);
    wr(icd_pkg::OFF_GO, 32'h0000_0001);
    wr(icd_pkg::OFF_WORD, 32'h0000_0000);
    wr(icd_pkg::OFF_SEL, sel(1'b1, 2'd1, 5'd23));
    rd("go read", icd_pkg::OFF_GO, 32'h0000_0000);
    rd("tag view", icd_pkg::OFF_WORD, 32'hABCD_E051);
    rd("tag check", icd_pkg::OFF_CHECK, 32'h0000_0075);
    wr(icd_pkg::OFF_SEL, sel(1'b1, 2'd2, 5'd16));
    rd("go read", icd_pkg::OFF_GO, 32'h0000_0000);
    rd("shared lru", icd_pkg::OFF_WORD, 32'h0000_0050);
    wr(icd_pkg::OFF_DBG, 32'h0000_0001);
    @(negedge pclk);
    chk("flush pulse", {31'h0, icache_flush}, 32'h1);
    @(negedge pclk);
    chk("flush end", {31'h0, icache_flush}, 32'h0);
    wr(icd_pkg::OFF_SEL, sel(1'b1, 2'd1, 5'd16));
    rd("go read", icd_pkg::OFF_GO, 32'h0000_0000);
    rd("after fence", icd_pkg::OFF_WORD, 32'hABCD_E050);
  endtask

  // region bits steer fetch cacheability; all clear turns the cache off
  task automatic t_region();
    rd("region", icd_pkg::OFF_REGION, 32'h0000_0004);
    wr(icd_pkg::OFF_REGION, 32'hFFFF_8001);
    rd("region", icd_pkg::OFF_REGION, 32'h0000_8001);
    chk("region out", {16'h0, region_cacheable}, 32'h0000_8001);
    chk("cache_enabled", {31'h0, cache_enabled}, 32'h1);
    fetch_addr <= 32'hF000_0000;
    @(negedge pclk);
    chk("fetch hi", {31'h0, fetch_cacheable}, 32'h1);
    @(posedge pclk);
    fetch_addr <= 32'h1000_0000;
    @(negedge pclk);
    chk("fetch mid", {31'h0, fetch_cacheable}, 32'h0);
    wr(icd_pkg::OFF_REGION, 32'h0000_0000);
    @(negedge pclk);
    chk("cache off", {31'h0, cache_enabled}, 32'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_select();
    t_refuse();
    t_line();
    t_tag();
    t_region();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire

// ===== icd_top.sv
// module: instruction cache diagnostic access, region cacheability and flush control
//
// Function
// - debugger fence request invalidates every instruction cache line, like a fence.
// - sixteen region cacheable bits; all clear turns the cache effectively off.
// - data, tag and status arrays are read and written through four registers.
// - selection register holds array choice, way number and line index.
// - words and tags live in check-protected arrays; valid and lru in flops.
// - array field 0 picks the data array, 1 picks tag and status.
// - way field selects one of four ways, 0 to 3.
// - reading the trigger with data array selected loads both data registers.
// - data read gives the 32-bit chunk and its check bits.
// - go written 1 with data array selected stores both data registers.
// - reading the trigger with tag selected loads tag, check, valid and lru.
// - tag read gives tag, valid, lru in word register, tag check bits separately.
// - go written 1 with tag selected stores tag, valid, lru and check bits.
// - check bits are stored exactly as written, allowing error injection.
// - reserved and unused register bits read as zero.
// - registers accept any write value and read back only legal values.
// - the whole cache control exists only when the build switch enables it.
// - diagnostic registers answer only in debug mode; otherwise an error results.
// - line index sits at bits 6:2, unused upper bits read zero.
`timescale 1ns/1ps
`default_nettype none
module icd_top #(
  parameter bit instr_cache_build_switch = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire icd_pkg::icd_apb_req_t apb_req,
  output var icd_pkg::icd_apb_rsp_t apb_rsp,
  // core context, same clock domain
  input wire logic debug_mode,
  input wire logic [31:0] fetch_addr,
  // cache control outputs
  output var logic [15:0] region_cacheable,
  output var logic cache_enabled,
  output var logic fetch_cacheable,
  output var logic icache_flush
);
  // ----------------------------------------------------------------
  // slot arithmetic
  // ----------------------------------------------------------------
  // data slot: way, set bit, chunk bits 3:0 of the index
  function automatic logic [6:0] data_slot(input logic [1:0] way,
                                           input logic [icd_pkg::IDX_W-1:0] idx);
    data_slot = {way, idx};
  endfunction

  // tag slot ignores the chunk bits of the index
  function automatic logic [2:0] tag_slot(input logic [1:0] way,
                                          input logic [icd_pkg::IDX_W-1:0] idx);
    tag_slot = {way, idx[icd_pkg::IDX_W-1]};
  endfunction

  // ----------------------------------------------------------------
  // state and bus decode
  // ----------------------------------------------------------------
  icd_pkg::icd_state_t s_q;
  icd_pkg::icd_state_t s_d;
  logic access;
  logic known;
  logic debug_only;
  logic bus_err;
  logic acc_ok;
  logic wr_ok;
  logic trig_rd;
  logic go_wr;
  logic fence_wr;
  logic [6:0] dslot;
  logic [2:0] tslot;
  logic set_bit;
  logic [31:0] tag_word;
  logic [31:0] rdata;

  assign access = apb_req.psel & apb_req.penable;
  // the region register stays reachable outside debug mode, the rest does not
  assign known = (apb_req.paddr == icd_pkg::OFF_SEL) | (apb_req.paddr == icd_pkg::OFF_WORD) |
                 (apb_req.paddr == icd_pkg::OFF_CHECK) | (apb_req.paddr == icd_pkg::OFF_GO) |
                 (apb_req.paddr == icd_pkg::OFF_REGION) | (apb_req.paddr == icd_pkg::OFF_DBG);
  assign debug_only = (apb_req.paddr != icd_pkg::OFF_REGION);
  // with the build switch off nothing answers except with an error
  assign bus_err = access & (!known | !instr_cache_build_switch |
                             (debug_only & !debug_mode));
  assign acc_ok = access & !bus_err;
  assign wr_ok = acc_ok & apb_req.pwrite;
  assign trig_rd = acc_ok & !apb_req.pwrite & (apb_req.paddr == icd_pkg::OFF_GO);
  assign go_wr = wr_ok & (apb_req.paddr == icd_pkg::OFF_GO) &
                 apb_req.pwdata[icd_pkg::GO_BIT];
  assign fence_wr = wr_ok & (apb_req.paddr == icd_pkg::OFF_DBG) &
                    apb_req.pwdata[icd_pkg::FENCE_BIT];
  assign dslot = data_slot(s_q.sel_way, s_q.sel_idx);
  assign tslot = tag_slot(s_q.sel_way, s_q.sel_idx);
  assign set_bit = s_q.sel_idx[icd_pkg::IDX_W-1];

  // tag view: tag, lru of the set, valid of the line; unused bits zero
  always_comb
  begin
    tag_word = 32'h0000_0000;
    tag_word[icd_pkg::TAG_LSB +: icd_pkg::TAG_W] = s_q.tag[tslot][icd_pkg::TAG_W-1:0];
    tag_word[icd_pkg::LRU_LSB +: icd_pkg::LRU_W] = s_q.lru[set_bit];
    tag_word[icd_pkg::VALID_BIT] = s_q.valid[tslot];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // a fence and a diagnostic write cannot share a cycle: both come over the one bus
  always_comb
  begin
    s_d = s_q;
    s_d.flush = fence_wr;
    if (wr_ok)
    begin
      unique case (apb_req.paddr)
        icd_pkg::OFF_SEL:
        begin
          // only implemented index bits are kept, so reads return a legal value
          s_d.sel_array = apb_req.pwdata[icd_pkg::SEL_ARRAY_BIT];
          s_d.sel_way = apb_req.pwdata[icd_pkg::SEL_WAY_LSB +: 2];
          s_d.sel_idx = apb_req.pwdata[icd_pkg::SEL_IDX_LSB +: icd_pkg::IDX_W];
        end
        icd_pkg::OFF_WORD:
        begin
          s_d.word = apb_req.pwdata;
        end
        icd_pkg::OFF_CHECK:
        begin
          s_d.check = apb_req.pwdata[icd_pkg::CHECK_W-1:0];
        end
        icd_pkg::OFF_REGION:
        begin
          s_d.cacheable = apb_req.pwdata[icd_pkg::REGIONS-1:0];
        end
        default:
        begin
          s_d.word = s_q.word;
        end
      endcase
    end
    // diagnostic store: check bits go in untouched, so errors can be injected
    if (go_wr)
    begin
      if (!s_q.sel_array)
      begin
        s_d.data[dslot] = {s_q.check, s_q.word};
      end
      else
      begin
        s_d.tag[tslot] = {s_q.check[icd_pkg::TCHK_W-1:0],
                          s_q.word[icd_pkg::TAG_LSB +: icd_pkg::TAG_W]};
        s_d.valid[tslot] = s_q.word[icd_pkg::VALID_BIT];
        s_d.lru[set_bit] = s_q.word[icd_pkg::LRU_LSB +: icd_pkg::LRU_W];
      end
    end
    // diagnostic fetch lands at the trigger edge, ahead of any later read
    if (trig_rd)
    begin
      if (!s_q.sel_array)
      begin
        s_d.word = s_q.data[dslot][31:0];
        s_d.check = s_q.data[dslot][icd_pkg::DATA_E_W-1:32];
      end
      else
      begin
        s_d.word = tag_word;
        s_d.check = {3'h0, s_q.tag[tslot][icd_pkg::TAG_E_W-1:icd_pkg::TAG_W]};
      end
    end
    // flush wipes only valid bits; data and tags stay for later inspection
    if (fence_wr)
    begin
      s_d.valid = '0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.word <= icd_pkg::RST_WORD;
      s_q.check <= icd_pkg::RST_CHECK;
      s_q.cacheable <= icd_pkg::RST_REGION;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  // trigger and fence registers are action-only and read as zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (acc_ok & !apb_req.pwrite)
    begin
      unique case (apb_req.paddr)
        icd_pkg::OFF_SEL:
        begin
          rdata[icd_pkg::SEL_ARRAY_BIT] = s_q.sel_array;
          rdata[icd_pkg::SEL_WAY_LSB +: 2] = s_q.sel_way;
          rdata[icd_pkg::SEL_IDX_LSB +: icd_pkg::IDX_W] = s_q.sel_idx;
        end
        icd_pkg::OFF_WORD:
        begin
          rdata = s_q.word;
        end
        icd_pkg::OFF_CHECK:
        begin
          rdata[icd_pkg::CHECK_W-1:0] = s_q.check;
        end
        icd_pkg::OFF_REGION:
        begin
          rdata[icd_pkg::REGIONS-1:0] = s_q.cacheable;
        end
        default:
        begin
          rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign apb_rsp.prdata = rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = bus_err;
  assign region_cacheable = s_q.cacheable;
  // with the cache left out, nothing is ever cacheable
  assign cache_enabled = instr_cache_build_switch & (|s_q.cacheable);
  assign fetch_cacheable = instr_cache_build_switch & s_q.cacheable[fetch_addr[31:28]];
  assign icache_flush = s_q.flush;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence data_trig_s;
    trig_rd && !s_q.sel_array;
  endsequence

  sequence tag_go_s;
    go_wr && s_q.sel_array;
  endsequence

  sequence tag_trig_s;
    trig_rd && s_q.sel_array;
  endsequence

  flush_clears_valid_a: assert property (fence_wr |=> (s_q.valid == '0) && icache_flush)
    else $error("fence did not clear valid bits");
  region_gate_a: assert property ((s_q.cacheable == '0) |-> !cache_enabled && !fetch_cacheable)
    else $error("cache enabled with no cacheable region");
  debug_only_a: assert property (access && debug_only && !debug_mode |-> apb_rsp.pslverr)
    else $error("diagnostic access outside debug mode not refused");
  data_read_a: assert property (data_trig_s |=> s_q.word == $past(s_q.data[dslot][31:0]))
    else $error("data read did not load the chunk");
  tag_read_a: assert property (trig_rd && s_q.sel_array |=> s_q.word == $past(tag_word))
    else $error("tag read did not load tag view");
  data_store_a: assert property (go_wr && !s_q.sel_array |=>
      s_q.data[$past(dslot)] == $past({s_q.check, s_q.word}))
    else $error("data store lost word or check bits");
  tag_store_a: assert property (tag_go_s |=>
      s_q.valid[$past(tslot)] == $past(s_q.word[icd_pkg::VALID_BIT]) &&
      s_q.tag[$past(tslot)] == $past({s_q.check[icd_pkg::TCHK_W-1:0],
      s_q.word[icd_pkg::TAG_LSB +: icd_pkg::TAG_W]}) &&
      s_q.lru[$past(set_bit)] == $past(s_q.word[icd_pkg::LRU_LSB +: icd_pkg::LRU_W]))
    else $error("tag store lost tag, valid or lru");
  sel_legal_a: assert property (acc_ok && !apb_req.pwrite &&
      apb_req.paddr == icd_pkg::OFF_SEL |-> (apb_rsp.prdata & 32'hFECF_FF83) == 32'h0000_0000)
    else $error("reserved selection bits read nonzero");
  ready_a: assert property (access |-> apb_rsp.pready)
    else $error("access not completed in first cycle");

  // refused accesses: no state change and no data on the bus
  refuse_quiet_a: assert property (bus_err |=> s_q.cacheable == $past(s_q.cacheable) &&
      s_q.word == $past(s_q.word) && s_q.sel_idx == $past(s_q.sel_idx))
    else $error("refused access changed state");
  refuse_zero_a: assert property (bus_err |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("refused access returned data");
  // action registers and unused check bits read as zero
  action_zero_a: assert property (acc_ok && !apb_req.pwrite &&
      (apb_req.paddr == icd_pkg::OFF_GO || apb_req.paddr == icd_pkg::OFF_DBG)
      |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("action register read nonzero");
  check_unused_a: assert property (acc_ok && !apb_req.pwrite &&
      apb_req.paddr == icd_pkg::OFF_CHECK |-> apb_rsp.prdata[31:icd_pkg::CHECK_W] == '0)
    else $error("unused check register bits read nonzero");
  // check bits of both arrays reach the check register on a fetch
  data_check_a: assert property (data_trig_s |=>
      s_q.check == $past(s_q.data[dslot][icd_pkg::DATA_E_W-1:32]))
    else $error("data read did not load check bits");
  tag_check_a: assert property (tag_trig_s |=>
      s_q.check == {3'h0, $past(s_q.tag[tslot][icd_pkg::TAG_E_W-1:icd_pkg::TAG_W])})
    else $error("tag read did not load tag check bits");
  // selection and region writes land as written
  sel_store_a: assert property (wr_ok && apb_req.paddr == icd_pkg::OFF_SEL |=>
      s_q.sel_array == $past(apb_req.pwdata[icd_pkg::SEL_ARRAY_BIT]) &&
      s_q.sel_way == $past(apb_req.pwdata[icd_pkg::SEL_WAY_LSB +: 2]))
    else $error("selection write lost array or way");
  region_store_a: assert property (wr_ok && apb_req.paddr == icd_pkg::OFF_REGION |=>
      s_q.cacheable == $past(apb_req.pwdata[icd_pkg::REGIONS-1:0]))
    else $error("region write not stored");
  // the flush pulse only ever follows a fence write
  flush_cause_a: assert property (icache_flush |-> $past(fence_wr))
    else $error("flush pulse without a fence write");
  fetch_gate_a: assert property (fetch_cacheable |-> cache_enabled)
    else $error("fetch cacheable while cache disabled");
  // a store into one array leaves the other one alone
  data_store_keep_a: assert property (go_wr && !s_q.sel_array |=>
      s_q.tag == $past(s_q.tag) && s_q.valid == $past(s_q.valid))
    else $error("data store disturbed the tag array");
  tag_store_keep_a: assert property (tag_go_s |=> s_q.data == $past(s_q.data))
    else $error("tag store disturbed the data array");
  // a fence keeps tags and lru for later inspection
  fence_keep_a: assert property (fence_wr |=> s_q.tag == $past(s_q.tag) &&
      s_q.lru == $past(s_q.lru))
    else $error("fence disturbed tags or lru");
  // word and check registers hold exactly what was written
  word_store_a: assert property (wr_ok && apb_req.paddr == icd_pkg::OFF_WORD |=>
      s_q.word == $past(apb_req.pwdata))
    else $error("word write not stored");
  check_store_a: assert property (wr_ok && apb_req.paddr == icd_pkg::OFF_CHECK |=>
      s_q.check == $past(apb_req.pwdata[icd_pkg::CHECK_W-1:0]))
    else $error("check write not stored");
endmodule // icd_top
`default_nettype wire
